// >>> design/pscx_ctl.sv
// protection switch, timing selection, indicators and cross-connect maps of the control card
//
// Summary of operation
// - optical port pairs with one dedicated protect port; failure moves traffic to protect
// - unidirectional mode: transmit and receive select independently
// - bidirectional mode: transmit and receive always select the same source
// - non-revertive: protect stays selected until manual switch-back
// - revertive: return to working once working recovers
// - reset default is unidirectional, non-revertive; revertive is configurable
// - electrical tributaries pair one working card with one protect card
// - electrical switch moves both directions; stays on protect until switch-back
// - slot 6 card is working, slot 5 protect; lone card sits in slot 6
// - any working card circuit failure moves all card functions to protect
// - control card switch completes well inside 50 ms
// - only optical may be unprotected; electrical always in a protection group
// - timing reference from line, building or internal; primary and secondary set
// - slow loop tracks reference; holdover keeps last frequency on loss
// - timing-lock lit when active card qualifies line or building reference
// - role indicator green when active, yellow when standby
// - separate critical, major, minor, remote indicators, each its own class
// - low-rate and high-rate signal-fail indicators from any failing input
// - STS matrix of 288 ports; bidirectional cross-connect uses two ports
// - matrix non-blocking and allows one input broadcast to many outputs
// - VT matrix 672x672 holding up to 672 VT1.5 cross-connects
// - each of 28 low-rate tributaries maps to its own VT1.5 of one STS-1
// - VT numbering group-first: VT1..VT7 first VT of groups 1..7, etc.
`timescale 1ns/1ps
`default_nettype none
`include "pscx_defines.svh"

module pscx_ctl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pscx_pkg::pscx_wb_req_t wb_i,
  input wire pscx_pkg::pscx_pins_t pins_i,
  input wire logic [15:0] ref_freq_i,
  input wire logic [8:0] sts_q_i,
  input wire logic [9:0] vt_q_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output pscx_pkg::pscx_led_t leds_o,
  output logic opt_rx_sel_o,
  output logic opt_tx_sel_o,
  output logic elec_sel_o,
  output logic card_active_o,
  output logic [1:0] timing_src_o,
  output logic holdover_o,
  output logic [15:0] freq_word_o,
  output logic [9:0] sts_src_o,
  output logic [10:0] vt_src_o
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    pscx_pkg::pscx_pins_t m1;
    pscx_pkg::pscx_pins_t m2;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic slot6;
    pscx_pkg::pscx_role_t role;
    pscx_pkg::pscx_sel_t rx_sel;
    pscx_pkg::pscx_sel_t tx_sel;
    pscx_pkg::pscx_sel_t el_sel;
    logic revert;
    logic bidir;
    logic unprot;
    logic swback;
    pscx_pkg::pscx_src_t prim;
    pscx_pkg::pscx_src_t sec;
    pscx_pkg::pscx_src_t cur;
    logic holdover;
    logic [15:0] freq;
    logic [5:0] div;
    logic [3:0] alarm;
    logic [4:0] trib_idx;
    logic xc_we;
    logic xc_conn;
    logic xc_bidir;
    logic xc_vt;
    logic [9:0] xc_a;
    logic [9:0] xc_b;
    logic rd_vt;
    logic [9:0] rd_idx;
    logic ack;
    logic [31:0] dat;
    pscx_pkg::pscx_led_t leds;
    logic [9:0] sts_src;
    logic [10:0] vt_src;
  } pscx_state_t;

  pscx_state_t st_reg;
  pscx_state_t st_next;

  // maps are indexed by output port and hold the input port feeding it
  logic [8:0] sts_map [0:`PSCX_STS_PORTS-1];
  logic [9:0] vt_map [0:`PSCX_VT_PORTS-1];
  logic [`PSCX_STS_PORTS-1:0] sts_vld_reg;
  logic [`PSCX_VT_PORTS-1:0] vt_vld_reg;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic pscx_pkg::pscx_sel_t pick(input pscx_pkg::pscx_sel_t cur,
      input logic w_fail, input logic p_fail, input logic rev, input logic back);
    pick = cur;
    if (cur == pscx_pkg::SEL_WORK) begin
      if (w_fail && !p_fail) begin
        pick = pscx_pkg::SEL_PROT;
      end
    end else if (!w_fail && (rev || back || p_fail)) begin
      pick = pscx_pkg::SEL_WORK;
    end
  endfunction

  function automatic logic src_ok(input pscx_pkg::pscx_src_t s, input logic [1:0] loss);
    case (s)
      pscx_pkg::SRC_LINE: src_ok = !loss[0];
      pscx_pkg::SRC_BUILDING: src_ok = !loss[1];
      default: src_ok = 1'b1;
    endcase
  endfunction

  function automatic logic [31:0] wmask(input logic [3:0] sel);
    wmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  logic act;
  logic req;
  logic [31:0] m;
  logic [31:0] wd;
  logic [31:0] rdata;
  logic signed [16:0] diff;
  logic [4:0] t_grp;
  logic [4:0] t_vt;
  logic [1:0] ok;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.swback = 1'b0;
    st_next.xc_we = 1'b0;
    st_next.m1 = pins_i;
    st_next.m2 = st_reg.m1;
    act = (st_reg.role == pscx_pkg::ROLE_ACTIVE);
    // the strap is caught only after the synchroniser has filled
    if (!st_reg.strap_done) begin
      if (st_reg.strap_cnt == `PSCX_STRAP_WAIT) begin
        st_next.slot6 = st_reg.m2.slot6_strap;
        st_next.strap_done = 1'b1;
      end else begin
        st_next.strap_cnt = st_reg.strap_cnt + 2'd1;
      end
    end

    // control card role: decided within a few cycles of a fail flag
    case (st_reg.role)
      pscx_pkg::ROLE_STANDBY: begin
        if (st_reg.strap_done && (|st_reg.m2.own_circuit_fail) == 1'b0) begin
          if (st_reg.slot6 || st_reg.m2.peer_fail) begin
            st_next.role = pscx_pkg::ROLE_ACTIVE;
          end
        end
      end
      pscx_pkg::ROLE_ACTIVE: begin
        if (|st_reg.m2.own_circuit_fail) begin
          // whole card yields, not only the failing circuit
          st_next.role = st_reg.slot6 ? pscx_pkg::ROLE_YIELDED
                                      : pscx_pkg::ROLE_STANDBY;
        end else if (!st_reg.slot6 && st_reg.swback && !st_reg.m2.peer_fail) begin
          st_next.role = pscx_pkg::ROLE_STANDBY;
        end
      end
      pscx_pkg::ROLE_YIELDED: begin
        if (st_reg.swback && (|st_reg.m2.own_circuit_fail) == 1'b0) begin
          st_next.role = pscx_pkg::ROLE_ACTIVE;
        end
      end
      default: st_next.role = pscx_pkg::ROLE_STANDBY;
    endcase

    // optical pair selection
    if (st_reg.unprot) begin
      st_next.rx_sel = pscx_pkg::SEL_WORK;
      st_next.tx_sel = pscx_pkg::SEL_WORK;
    end else if (st_reg.bidir) begin
      st_next.rx_sel = pick(st_reg.rx_sel,
        st_reg.m2.opt_work_rx_fail | st_reg.m2.opt_work_tx_fail,
        st_reg.m2.opt_prot_rx_fail | st_reg.m2.opt_prot_tx_fail,
        st_reg.revert, st_reg.swback);
      st_next.tx_sel = st_next.rx_sel;
    end else begin
      st_next.rx_sel = pick(st_reg.rx_sel, st_reg.m2.opt_work_rx_fail,
        st_reg.m2.opt_prot_rx_fail, st_reg.revert, st_reg.swback);
      st_next.tx_sel = pick(st_reg.tx_sel, st_reg.m2.opt_work_tx_fail,
        st_reg.m2.opt_prot_tx_fail, st_reg.revert, st_reg.swback);
    end
    // electrical group has no unprotected form and never reverts on its own
    st_next.el_sel = pick(st_reg.el_sel, st_reg.m2.elec_work_fail,
      st_reg.m2.elec_prot_fail, 1'b0, st_reg.swback);

    // timing reference selection and holdover
    ok[0] = src_ok(st_reg.prim, st_reg.m2.ref_loss);
    ok[1] = src_ok(st_reg.sec, st_reg.m2.ref_loss);
    st_next.holdover = 1'b0;
    if (ok[0]) begin
      st_next.cur = st_reg.prim;
    end else if (ok[1]) begin
      st_next.cur = st_reg.sec;
    end else begin
      st_next.holdover = 1'b1;
    end
    // slow loop: one sixteenth of the error per microsecond tick
    diff = $signed({1'b0, ref_freq_i}) - $signed({1'b0, st_reg.freq});
    if (st_reg.div == `PSCX_TRACK_DIV) begin
      st_next.div = 6'd0;
      if (!st_reg.holdover) begin
        st_next.freq = st_reg.freq + 16'(diff >>> 4);
      end
    end else begin
      st_next.div = st_reg.div + 6'd1;
    end

    // indicators
    st_next.leds.role_indicator_green = act;
    st_next.leds.role_indicator_yellow = !act;
    st_next.leds.timing_lock_indicator = act && !st_reg.holdover &&
      (st_reg.cur == pscx_pkg::SRC_LINE || st_reg.cur == pscx_pkg::SRC_BUILDING);
    st_next.leds.critical_alarm_indicator = st_reg.alarm[0];
    st_next.leds.major_alarm_indicator = st_reg.alarm[1];
    st_next.leds.minor_alarm_indicator = st_reg.alarm[2];
    st_next.leds.remote_alarm_indicator = st_reg.alarm[3];
    st_next.leds.low_rate_signal_fail_indicator = |st_reg.m2.low_rate_fail;
    st_next.leds.high_rate_signal_fail_indicator = |st_reg.m2.high_rate_fail;

    // matrix lookups: a standby card steers nothing
    st_next.sts_src = 10'h000;
    if (act && {1'b0, sts_q_i} < `PSCX_STS_PORTS && sts_vld_reg[sts_q_i]) begin
      st_next.sts_src = {1'b1, sts_map[sts_q_i]};
    end
    st_next.vt_src = 11'h000;
    if (act && vt_q_i < `PSCX_VT_PORTS && vt_vld_reg[vt_q_i]) begin
      st_next.vt_src = {1'b1, vt_map[vt_q_i]};
    end

    // tributary to VT numbering, group first
    t_grp = 5'd0;
    t_vt = 5'd0;
    if (st_reg.trib_idx < `PSCX_TRIBS) begin
      t_grp = 5'(st_reg.trib_idx % `PSCX_VT_GROUPS) + 5'd1;
      t_vt = 5'(st_reg.trib_idx / `PSCX_VT_GROUPS) + 5'd1;
    end

    // -----------------------------------------------------------------
    // register bus
    // -----------------------------------------------------------------
    case (wb_i.adr)
      `PSCX_ADR_CTRL: rdata = {29'h0000_0000, st_reg.unprot, st_reg.bidir, st_reg.revert};
      `PSCX_ADR_TIMING: rdata = {28'h000_0000, st_reg.sec, st_reg.prim};
      `PSCX_ADR_STATUS: rdata = {st_reg.freq, 7'h00, st_reg.holdover, st_reg.cur,
        st_reg.role, st_reg.slot6, st_reg.el_sel, st_reg.tx_sel, st_reg.rx_sel};
      `PSCX_ADR_ALARM: rdata = {28'h000_0000, st_reg.alarm};
      `PSCX_ADR_XCRD: begin
        rdata = {1'b0, st_reg.rd_vt, 30'h0000_0000};
        if (st_reg.rd_vt && st_reg.rd_idx < `PSCX_VT_PORTS && vt_vld_reg[st_reg.rd_idx]) begin
          rdata[20:0] = {1'b1, vt_map[st_reg.rd_idx], st_reg.rd_idx};
        end else if (!st_reg.rd_vt && st_reg.rd_idx < `PSCX_STS_PORTS &&
                     sts_vld_reg[st_reg.rd_idx[8:0]]) begin
          rdata[20:0] = {1'b1, 1'b0, sts_map[st_reg.rd_idx[8:0]], st_reg.rd_idx};
        end
      end
      `PSCX_ADR_TRIB: rdata = {3'h0, t_vt, 3'h0, t_grp, 11'h000, st_reg.trib_idx};
      default: rdata = 32'h0000_0000;
    endcase
    req = wb_i.cyc && wb_i.stb && !st_reg.ack;
    m = wmask(wb_i.sel);
    wd = (rdata & ~m) | (wb_i.dat & m);
    if (req) begin
      st_next.ack = 1'b1;
      st_next.dat = wb_i.we ? 32'h0000_0000 : rdata;
      if (wb_i.we) begin
        case (wb_i.adr)
          `PSCX_ADR_CTRL: begin
            st_next.revert = wd[`PSCX_CTRL_REVERT];
            st_next.bidir = wd[`PSCX_CTRL_BIDIR];
            st_next.unprot = wd[`PSCX_CTRL_UNPROT];
            st_next.swback = wd[`PSCX_CTRL_SWBACK];
          end
          `PSCX_ADR_TIMING: begin
            st_next.prim = pscx_pkg::pscx_src_t'(wd[1:0]);
            st_next.sec = pscx_pkg::pscx_src_t'(wd[3:2]);
          end
          `PSCX_ADR_ALARM: st_next.alarm = wd[3:0];
          `PSCX_ADR_XC: begin
            st_next.xc_we = 1'b1;
            st_next.xc_a = wd[9:0];
            st_next.xc_b = wd[19:10];
            st_next.xc_bidir = wd[`PSCX_XC_BIDIR];
            st_next.xc_vt = wd[`PSCX_XC_VT];
            st_next.xc_conn = wd[`PSCX_XC_CONNECT];
          end
          `PSCX_ADR_XCRD: begin
            st_next.rd_idx = wd[9:0];
            st_next.rd_vt = wd[`PSCX_XC_VT];
          end
          `PSCX_ADR_TRIB: st_next.trib_idx = wd[4:0];
          default: st_next.dat = 32'h0000_0000;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.revert <= 1'(`PSCX_CTRL_RESET >> `PSCX_CTRL_REVERT);
      st_reg.bidir <= 1'(`PSCX_CTRL_RESET >> `PSCX_CTRL_BIDIR);
      st_reg.prim <= pscx_pkg::pscx_src_t'(2'(`PSCX_TIMING_RESET));
      st_reg.sec <= pscx_pkg::pscx_src_t'(2'(`PSCX_TIMING_RESET >> 2));
      st_reg.cur <= pscx_pkg::SRC_INTERNAL;
      st_reg.leds.role_indicator_yellow <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // writes are range checked; a bidirectional entry takes both ports
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_vld_reg <= '0;
      vt_vld_reg <= '0;
    end else if (st_reg.xc_we) begin
      if (!st_reg.xc_vt && st_reg.xc_a < `PSCX_STS_PORTS && st_reg.xc_b < `PSCX_STS_PORTS) begin
        sts_vld_reg[st_reg.xc_a[8:0]] <= st_reg.xc_conn;
        if (st_reg.xc_bidir) begin
          sts_vld_reg[st_reg.xc_b[8:0]] <= st_reg.xc_conn;
        end
      end
      if (st_reg.xc_vt && st_reg.xc_a < `PSCX_VT_PORTS && st_reg.xc_b < `PSCX_VT_PORTS) begin
        vt_vld_reg[st_reg.xc_a] <= st_reg.xc_conn;
        if (st_reg.xc_bidir) begin
          vt_vld_reg[st_reg.xc_b] <= st_reg.xc_conn;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (st_reg.xc_we) begin
      if (!st_reg.xc_vt && st_reg.xc_a < `PSCX_STS_PORTS && st_reg.xc_b < `PSCX_STS_PORTS) begin
        sts_map[st_reg.xc_a[8:0]] <= st_reg.xc_b[8:0];
        if (st_reg.xc_bidir) begin
          sts_map[st_reg.xc_b[8:0]] <= st_reg.xc_a[8:0];
        end
      end
      if (st_reg.xc_vt && st_reg.xc_a < `PSCX_VT_PORTS && st_reg.xc_b < `PSCX_VT_PORTS) begin
        vt_map[st_reg.xc_a] <= st_reg.xc_b;
        if (st_reg.xc_bidir) begin
          vt_map[st_reg.xc_b] <= st_reg.xc_a;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.dat;
  assign leds_o = st_reg.leds;
  assign opt_rx_sel_o = st_reg.rx_sel;
  assign opt_tx_sel_o = st_reg.tx_sel;
  assign elec_sel_o = st_reg.el_sel;
  assign card_active_o = st_reg.leds.role_indicator_green;
  assign timing_src_o = st_reg.cur;
  assign holdover_o = st_reg.holdover;
  assign freq_word_o = st_reg.freq;
  assign sts_src_o = st_reg.sts_src;
  assign vt_src_o = st_reg.vt_src;

endmodule
`default_nettype wire

// >>> pkg/pscx_defines.svh
// register offsets, field positions, reset values and timing counts of the switch controller
`ifndef PSCX_DEFINES_SVH
`define PSCX_DEFINES_SVH
`define PSCX_ADR_CTRL 8'h00
`define PSCX_ADR_TIMING 8'h04
`define PSCX_ADR_STATUS 8'h08
`define PSCX_ADR_ALARM 8'h0C
`define PSCX_ADR_XC 8'h10
`define PSCX_ADR_XCRD 8'h14
`define PSCX_ADR_TRIB 8'h18
`define PSCX_CTRL_REVERT 0
`define PSCX_CTRL_BIDIR 1
`define PSCX_CTRL_UNPROT 2
`define PSCX_CTRL_SWBACK 3
`define PSCX_CTRL_RESET 32'h0000_0000
`define PSCX_TIMING_RESET 32'h0000_0008
`define PSCX_XC_BIDIR 29
`define PSCX_XC_VT 30
`define PSCX_XC_CONNECT 31
`define PSCX_STS_PORTS 10'd288
`define PSCX_VT_PORTS 10'd672
`define PSCX_TRIBS 5'd28
`define PSCX_VT_GROUPS 5'd7
`define PSCX_STRAP_WAIT 2'd3
`define PSCX_CLK_NS 25
`define PSCX_TRACK_TICK_NS 1000
`define PSCX_TRACK_DIV 6'((`PSCX_TRACK_TICK_NS / `PSCX_CLK_NS) - 1)
`define PSCX_SWITCH_MAX_NS 50000000
`define PSCX_SWITCH_MAX_CYC (`PSCX_SWITCH_MAX_NS / `PSCX_CLK_NS)
`endif

// >>> pkg/pscx_pkg.sv
// types shared by the protection switch and cross-connect controller
package pscx_pkg;
  typedef enum logic {SEL_WORK = 1'b0, SEL_PROT = 1'b1} pscx_sel_t;
  typedef enum logic [1:0] {
    ROLE_STANDBY = 2'b00,
    ROLE_ACTIVE = 2'b01,
    ROLE_YIELDED = 2'b11
  } pscx_role_t;
  typedef enum logic [1:0] {
    SRC_LINE = 2'b00,
    SRC_BUILDING = 2'b01,
    SRC_INTERNAL = 2'b10,
    SRC_SPARE = 2'b11
  } pscx_src_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pscx_wb_req_t;
  typedef struct packed {
    logic opt_work_rx_fail;
    logic opt_work_tx_fail;
    logic opt_prot_rx_fail;
    logic opt_prot_tx_fail;
    logic elec_work_fail;
    logic elec_prot_fail;
    logic [3:0] own_circuit_fail;
    logic peer_fail;
    logic slot6_strap;
    logic [1:0] ref_loss;
    logic [27:0] low_rate_fail;
    logic [2:0] high_rate_fail;
  } pscx_pins_t;
  typedef struct packed {
    logic role_indicator_green;
    logic role_indicator_yellow;
    logic timing_lock_indicator;
    logic critical_alarm_indicator;
    logic major_alarm_indicator;
    logic minor_alarm_indicator;
    logic remote_alarm_indicator;
    logic low_rate_signal_fail_indicator;
    logic high_rate_signal_fail_indicator;
  } pscx_led_t;
endpackage

// >>> verif/pscx_ctl_sva.sv
// port checker for the switch and cross-connect controller
`timescale 1ns/1ps
`default_nettype none
module pscx_ctl_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pscx_pkg::pscx_wb_req_t wb_i,
  input wire pscx_pkg::pscx_pins_t pins_i,
  input wire logic wb_ack_o,
  input wire pscx_pkg::pscx_led_t leds_o,
  input wire logic opt_rx_sel_o,
  input wire logic elec_sel_o,
  input wire logic card_active_o,
  input wire logic holdover_o,
  input wire logic [1:0] timing_src_o,
  input wire logic [15:0] freq_word_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // bus and lamps
  // ----
  a_ack_next_edge: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_role_lamp_match: assert property (leds_o.role_indicator_green == card_active_o
    && (leds_o.role_indicator_green != leds_o.role_indicator_yellow))
    else $error("role lamp wrong");
  a_low_rate_on: assert property ((|pins_i.low_rate_fail) [*5]
    |-> leds_o.low_rate_signal_fail_indicator) else $error("low rate lamp dark");
  a_low_rate_off: assert property ((pins_i.low_rate_fail == '0) [*5]
    |-> !leds_o.low_rate_signal_fail_indicator) else $error("low rate lamp lit");
  // ----
  // timing and protection
  // ----
  // an internal source is never lost, so holdover is only owed off line and building
  a_holdover_entry: assert property ((&pins_i.ref_loss) [*8] |-> holdover_o
    || timing_src_o[1])
    else $error("no holdover");
  a_freq_frozen: assert property (holdover_o ##1 holdover_o |-> $stable(freq_word_o))
    else $error("frequency moved in holdover");
  a_rx_sel_cause: assert property ($rose(opt_rx_sel_o) |->
    $past(pins_i.opt_work_rx_fail, 3) || $past(pins_i.opt_work_tx_fail, 3)
    || $past(pins_i.opt_work_rx_fail, 4) || $past(pins_i.opt_work_tx_fail, 4))
    else $error("protect chosen without fail");
  a_elec_sel_cause: assert property ($rose(elec_sel_o) |->
    $past(pins_i.elec_work_fail, 3) || $past(pins_i.elec_work_fail, 4))
    else $error("electrical protect without fail");
  a_yield_fault: assert property ((|pins_i.own_circuit_fail) [*6] |-> !card_active_o)
    else $error("faulty card still active");
  c_rx_protect: cover property ($rose(opt_rx_sel_o));
  c_elec_protect: cover property ($rose(elec_sel_o));
  c_holdover: cover property ($rose(holdover_o));
  c_yield: cover property ($fell(card_active_o));
endmodule
bind pscx_ctl pscx_ctl_sva pscx_ctl_sva_inst (.clk_i, .rst_i, .wb_i, .pins_i, .wb_ack_o,
  .leds_o, .opt_rx_sel_o, .elec_sel_o, .card_active_o, .holdover_o, .timing_src_o,
  .freq_word_o);
`default_nettype wire

// >>> verif/pscx_ctl_test.sv
// self-checking bench for the switch and cross-connect controller
`timescale 1ns/1ps
`default_nettype none
`include "pscx_defines.svh"
module pscx_ctl_test;
  logic clk_i, wb_ack_o, opt_rx_sel_o, opt_tx_sel_o, elec_sel_o, card_active_o, holdover_o;
  logic rst_i = 1'h1;
  pscx_pkg::pscx_wb_req_t wb_i = '0;
  pscx_pkg::pscx_pins_t pins_i, base, p;
  pscx_pkg::pscx_pins_t want = '0;
  pscx_pkg::pscx_led_t leds_o;
  logic [15:0] ref_freq_i, freq_word_o;
  logic [15:0] ref_tgt = 16'h0000;
  logic [8:0] sts_q_i = 9'h000;
  logic [9:0] vt_q_i = 10'h000;
  logic [9:0] sts_src_o;
  logic [10:0] vt_src_o;
  logic [31:0] wb_dat_o, rd, f0;
  logic [1:0] timing_src_o;
  int err_total, n_checks, i, b, a;
  pscx_ctl pscx_ctl_inst (.clk_i, .rst_i, .wb_i, .pins_i, .ref_freq_i, .sts_q_i, .vt_q_i,
    .wb_ack_o, .wb_dat_o, .leds_o, .opt_rx_sel_o, .opt_tx_sel_o, .elec_sel_o,
    .card_active_o, .timing_src_o, .holdover_o, .freq_word_o, .sts_src_o, .vt_src_o);
  pscx_far_end pscx_far_end_inst (.clk_i, .want_i(want), .ref_target_i(ref_tgt),
    .pins_o(pins_i), .ref_freq_o(ref_freq_i));
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  // ----
  // helpers
  // ----
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // outputs are read at the falling edge; the bus takes ack and data at the rising edge
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{1'h1, 1'h1, we, adr, 4'hf, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (n >= 20) err_total++;
    rd = wb_dat_o;
    wb_i <= '0;
  endtask
  task automatic setp(input pscx_pkg::pscx_pins_t v);
    @(posedge clk_i);
    want <= v;
    wt(7);
  endtask
  task automatic look(input int s, input int v);
    @(posedge clk_i);
    sts_q_i <= 9'(s);
    vt_q_i <= 10'(v);
    wt(3);
  endtask
  task automatic xc(input logic [31:0] d);
    bus(1'h1, `PSCX_ADR_XC, d);
    wt(2);
  endtask
  function automatic logic [31:0] sels();
    return {29'h0, elec_sel_o, opt_tx_sel_o, opt_rx_sel_o};
  endfunction
  task automatic prot(input logic [3:0] cfg, input int k, input logic [2:0] ef,
    input logic [2:0] ec);
    pscx_pkg::pscx_pins_t f;
    f = base;
    f.opt_work_rx_fail = (k == 0);
    f.opt_work_tx_fail = (k == 1);
    f.elec_work_fail = (k == 2);
    bus(1'h1, `PSCX_ADR_CTRL, {28'h0, cfg});
    setp(f);
    chk("sel on fail", sels(), {29'h0, ef});
    setp(base);
    chk("sel on recovery", sels(), {29'h0, ec});
    bus(1'h1, `PSCX_ADR_CTRL, {28'h0, cfg | 4'h8});
    wt(6);
    chk("sel after switch-back", sels(), 32'h0);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(32'h7716_f090));
    base = '0;
    base.slot6_strap = 1'h1;
    want = base;
    ref_tgt = 16'($urandom);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    wt(1);
    chk("reset lamps", 32'(leds_o), 32'h0000_0080);
    chk("reset outputs", 32'({timing_src_o, elec_sel_o, opt_tx_sel_o, opt_rx_sel_o,
      card_active_o, holdover_o}), 32'h0000_0040);
    bus(1'h0, `PSCX_ADR_CTRL, 32'h0);
    chk("ctrl reset", rd, `PSCX_CTRL_RESET);
    bus(1'h0, `PSCX_ADR_TIMING, 32'h0);
    chk("timing reset", rd, `PSCX_TIMING_RESET);
    bus(1'h0, 8'h1c, 32'h0);
    chk("unmapped read", rd, 32'h0);
    wt(4);
    chk("slot 6 role", 32'({card_active_o, leds_o.role_indicator_green}), 32'h3);
    bus(1'h0, `PSCX_ADR_STATUS, 32'h0);
    chk("status word", rd & 32'h0000_ffff, 32'h0000_0018);
    prot(4'h0, 0, 3'h1, 3'h1);
    prot(4'h0, 1, 3'h2, 3'h2);
    prot(4'h2, 1, 3'h3, 3'h3);
    prot(4'h1, 0, 3'h1, 3'h0);
    prot(4'h4, 0, 3'h0, 3'h0);
    prot(4'h1, 2, 3'h4, 3'h4);
    bus(1'h1, `PSCX_ADR_CTRL, 32'h0);
    for (i = 0; i < 4; i++) begin
      bus(1'h1, `PSCX_ADR_ALARM, 32'h1 << i);
      wt(3);
      chk("alarm lamps", 32'(leds_o[5:2]), 32'h8 >> i);
    end
    p = base;
    p.low_rate_fail[$urandom % 28] = 1'h1;
    setp(p);
    chk("rate lamps", 32'(leds_o[1:0]), 32'h2);
    p.high_rate_fail[$urandom % 3] = 1'h1;
    setp(p);
    chk("rate lamps", 32'(leds_o[1:0]), 32'h3);
    setp(base);
    chk("rate lamps", 32'(leds_o[1:0]), 32'h0);
    for (i = 0; i < 29; i++) begin
      bus(1'h1, `PSCX_ADR_TRIB, 32'(i));
      bus(1'h0, `PSCX_ADR_TRIB, 32'h0);
      chk("trib map", rd & 32'h1f1f_0000,
        (i < 28) ? ((32'(i / 7 + 1) << 24) | (32'(i % 7 + 1) << 16)) : 32'h0);
    end
    // long enough for the slow loop to settle within one step of the target
    wt(6000);
    chk("tracked frequency", 32'((32'(ref_tgt) - 32'(freq_word_o)) < 32'd16), 32'h1);
    bus(1'h1, `PSCX_ADR_TIMING, 32'h1);
    wt(6);
    chk("timing source", 32'(timing_src_o), 32'h1);
    chk("timing lock", 32'(leds_o.timing_lock_indicator), 32'h1);
    p = base;
    p.ref_loss = 2'h2;
    setp(p);
    chk("fallback source", 32'(timing_src_o), 32'h0);
    p.ref_loss = 2'h3;
    setp(p);
    f0 = 32'(freq_word_o);
    chk("holdover", 32'(holdover_o), 32'h1);
    wt(200);
    chk("held frequency", 32'(freq_word_o), f0);
    setp(base);
    b = $urandom % 288;
    a = $urandom % 144;
    xc(32'h8000_0000 | (b << 10) | a);
    xc(32'h8000_0000 | (b << 10) | (a + 144));
    look(a, 0);
    chk("sts map", 32'(sts_src_o), 32'h200 | b);
    look(a + 144, 0);
    chk("sts broadcast", 32'(sts_src_o), 32'h200 | b);
    bus(1'h1, `PSCX_ADR_XCRD, a);
    bus(1'h0, `PSCX_ADR_XCRD, 32'h0);
    chk("xc readback", rd, 32'h0010_0000 | (b << 10) | a);
    xc(32'ha000_0000 | (32'h3 << 10) | 32'd287);
    look(3, 0);
    chk("sts reverse", 32'(sts_src_o), 32'h200 | 32'd287);
    xc(32'h8000_0000 | 32'd288);
    look(288, 0);
    chk("sts out of range", 32'(sts_src_o[9]), 32'h0);
    xc(32'hc000_0000 | (32'h5 << 10) | 32'd671);
    look(0, 671);
    chk("vt map", 32'(vt_src_o), 32'h405);
    p = base;
    p.own_circuit_fail[$urandom % 4] = 1'h1;
    setp(p);
    chk("yield on fault", 32'(card_active_o), 32'h0);
    @(posedge clk_i);
    rst_i <= 1'h1;
    want <= '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    wt(12);
    chk("slot 5 standby", 32'({card_active_o, leds_o.role_indicator_yellow}), 32'h1);
    p = '0;
    p.peer_fail = 1'h1;
    setp(p);
    chk("slot 5 takes over", 32'(card_active_o), 32'h1);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// >>> verif/pscx_far_end.sv
// model of the line cards and the peer control card across the backplane
`timescale 1ns/1ps
`default_nettype none
module pscx_far_end (
  input wire logic clk_i,
  input wire pscx_pkg::pscx_pins_t want_i,
  input wire logic [15:0] ref_target_i,
  output var pscx_pkg::pscx_pins_t pins_o,
  output var logic [15:0] ref_freq_o
);
  // ----
  // fail flags and reference word
  // ----
  initial pins_o = '0;
  initial ref_freq_o = 16'h0000;
  always @(posedge clk_i) begin
    // every pin of want_i is handed over a cycle later: fail flags, reference loss bits and the slot 6 strap
    pins_o <= want_i;
    // with both references lost there is no usable word, so it toggles every cycle
    if (&want_i.ref_loss) begin
      ref_freq_o <= ~ref_freq_o;
    end else begin
      ref_freq_o <= ref_target_i;
    end
  end
endmodule
`default_nettype wire
